// ==== gpm_consts.svh ====
// Register offsets, reset values and field positions of the pin-mux port.
`ifndef GPM_CONSTS_SVH
`define GPM_CONSTS_SVH
// ==========================================================================
// Register byte offsets
`define GPM_OFS_MODE      8'h00
`define GPM_OFS_OTYPE     8'h04
`define GPM_OFS_DRIVE     8'h08
`define GPM_OFS_PULL      8'h0C
`define GPM_OFS_INPUT     8'h10
`define GPM_OFS_LATCH     8'h14
`define GPM_OFS_SETCLR    8'h18
`define GPM_OFS_LOCK      8'h1C
`define GPM_OFS_ALTLO     8'h20
`define GPM_OFS_ALTHI     8'h24
`define GPM_OFS_BITCLR    8'h28
`define GPM_OFS_TOGGLE    8'h2C
`define GPM_OFS_HUGE      8'h3C
// ==========================================================================
// Reset values per port flavour
`define GPM_MODE_RST_A    32'h2800_0000
`define GPM_MODE_RST_B    32'h0000_0080
`define GPM_DRIVE_RST_B   32'h0000_00C0
`define GPM_PULL_RST_A    32'h2400_0000
`define GPM_ZERO_RST      32'h0000_0000
// ==========================================================================
// Field positions
`define GPM_LOCK_SEQ_BIT  16
`define GPM_CLR_LSB       16
// ==========================================================================
// Port flavour codes
`define GPM_PORT_A        2'h0
`define GPM_PORT_B        2'h1
`define GPM_PORT_OTHER    2'h2
// ==========================================================================
// AXI response codes
`define GPM_RESP_OKAY     2'h0
`define GPM_RESP_SLVERR   2'h2
`endif

// ==== gpm_pkg.sv ====
// Types shared by the pin-mux port.
package gpm_pkg;
	// ======================================================================
	// Pin mode codes
	typedef enum logic [1:0] {
		GPM_MODE_INPUT  = 2'h0,
		GPM_MODE_OUTPUT = 2'h1,
		GPM_MODE_ALT    = 2'h2,
		GPM_MODE_ANALOG = 2'h3
	} gpm_mode_t;

	// Lock sequence states, one-hot.
	typedef enum logic [4:0] {
		GPM_LK_IDLE  = 5'h01,
		GPM_LK_ONE   = 5'h02,
		GPM_LK_ZERO  = 5'h04,
		GPM_LK_TWO   = 5'h08,
		GPM_LK_DONE  = 5'h10
	} gpm_lock_t;

	// Per-pin pad controls handed to the pad ring.
	typedef struct packed {
		logic [15:0] out;
		logic [15:0] oe_b;
		logic [15:0] pull_up;
		logic [15:0] pull_down;
		logic [15:0] large_drive;
		logic [15:0] huge_drive;
		logic [15:0] analog;
	} gpm_pad_t;

	// Hardware owner enables, already decoded by their own blocks.
	typedef struct packed {
		logic [15:0] own;
		logic [15:0] out;
		logic [15:0] oe_b;
	} gpm_owner_t;

	// AXI4-Lite answer channels.
	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} gpm_axi_t;

	// Whole state of the port.
	typedef struct packed {
		gpm_axi_t    axi;
		logic        aw_held;
		logic [7:0]  aw_addr;
		logic        w_held;
		logic [31:0] w_data;
		logic [3:0]  w_strb;
		logic [31:0] mode;
		logic [15:0] otype;
		logic [31:0] drive;
		logic [31:0] pull;
		logic [15:0] latch;
		logic [15:0] lock_mask;
		logic        lock_seq;
		logic        locked;
		gpm_lock_t   lock_st;
		logic [31:0] alt_lo;
		logic [31:0] alt_hi;
		logic [15:0] huge;
		logic [15:0] in_smp;
		gpm_pad_t    pad;
		logic [15:0] alt_sel_valid;
	} gpm_state_t;
endpackage : gpm_pkg

// ==== gpm_port.sv ====
// GPIO port with per-pin configuration, alternate-function mux and lock.
//
// Contract
// - Two-bit mode per pin: input at reset (alternate for pins 13, 14 on port A and pin 3 on port B), output, alternate, analog.
// - Output-type bit per pin: push-pull when 0, open-drain when 1.
// - Drive field: codes x0 and 11 normal, code 01 large.
// - Pull field: 00 none, 01 pull-up, 10 pull-down.
// - Input register read-only, sampled pin levels low half, upper half zero.
// - Output latch, one bit per pin, drives pin level in output mode, resets zero.
// - Set/clear write: low half ones set, high half ones clear latch.
// - Set and clear both one for a pin: set wins.
// - Bit-clear register write: ones clear matching latch bits.
// - Toggle register write-only: ones invert matching latch bits.
// - Lock takes effect only after write 1, write 0, write 1, read.
// - Low mux register: four-bit selectors for pins 0 to 7.
// - High mux register: selectors for pins 8 to 15, reset zero.
// - Huge-drive bit per pin switches to maximum strength when set.
// - Mode reset 0x28000000 port A, 0x00000080 port B, else zero.
// - Drive reset 0x000000C0 port B, zero elsewhere.
// - Pull reset 0x24000000 port A, zero on port B.
// - Registers accept byte, half-word and word accesses.
// - Enabled hardware owner takes pin regardless of its configuration.
// - Oscillator pins handed over by clock-control and backup bits.
// - Power-control wake enables hand their pins to wake inputs.
// - Alternate mode output and enable come from selected peripheral.
// - Each pin connects to exactly one peripheral signal at a time.
`timescale 1ns/1ps
`include "gpm_consts.svh"

module gpm_port #(
	parameter logic [1:0] PORT_KIND = `GPM_PORT_A,
	parameter int         PINS      = 16
) (
	input  wire logic                  clk,
	input  wire logic                  rst_b,
	input  wire logic [7:0]            s_axi_awaddr,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	output logic [1:0]                 s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	input  wire logic [7:0]            s_axi_araddr,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	output logic [31:0]                s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	input  wire logic [15:0]           pin_in,
	input  wire logic [16*PINS-1:0]    periph_out,
	input  wire logic [16*PINS-1:0]    periph_oe_b,
	input  wire gpm_pkg::gpm_owner_t   owner,
	output logic [15:0]                pin_out,
	output logic [15:0]                pin_oe_b,
	output logic [15:0]                pin_pull_up,
	output logic [15:0]                pin_pull_down,
	output logic [15:0]                pin_large_drive,
	output logic [15:0]                pin_huge_drive,
	output logic [15:0]                pin_analog,
	output logic [15:0]                alt_in_valid,
	output logic                       config_locked
);
	// ======================================================================
	// Reset values chosen by port flavour
	localparam logic [31:0] MODE_RST  = (PORT_KIND == `GPM_PORT_A) ? `GPM_MODE_RST_A :
		(PORT_KIND == `GPM_PORT_B) ? `GPM_MODE_RST_B : `GPM_ZERO_RST;
	localparam logic [31:0] DRIVE_RST = (PORT_KIND == `GPM_PORT_B) ?
		`GPM_DRIVE_RST_B : `GPM_ZERO_RST;
	localparam logic [31:0] PULL_RST  = (PORT_KIND == `GPM_PORT_A) ?
		`GPM_PULL_RST_A : `GPM_ZERO_RST;

	gpm_pkg::gpm_state_t s_r;
	gpm_pkg::gpm_state_t s_nxt;

	logic [31:0] wmask;
	logic [31:0] wd;
	logic [31:0] rd_val;
	logic        rd_hit;
	logic        wr_hit;
	logic        do_wr;
	logic        do_rd;
	logic        lk_abort;
	logic [15:0] cfg_ok;
	logic [31:0] cfg2_ok;
	logic [31:0] cfg4_lo;
	logic [31:0] cfg4_hi;
	logic [15:0] alt_out;
	logic [15:0] alt_oe_b;

	// ======================================================================
	// Alternate-function mux: one peripheral signal per pin
	genvar g;
	generate
		for (g = 0; g < 16; g++) begin : g_pin
			logic [3:0] sel;
			assign sel = (g < 8) ? s_r.alt_lo[4*(g%8)+:4] : s_r.alt_hi[4*(g%8)+:4];
			assign alt_out[g]  = periph_out[16*g + int'(sel)];
			assign alt_oe_b[g] = periph_oe_b[16*g + int'(sel)];
			assign cfg_ok[g]  = !(s_r.locked && s_r.lock_mask[g]);
			assign cfg2_ok[2*g+:2] = {2{cfg_ok[g]}};
			// Each nibble has one driver: the low mux guards pins 0 to 7, the high one 8 to 15.
			if (g < 8) begin : g_lo
				assign cfg4_lo[4*g+:4] = {4{cfg_ok[g]}};
			end else begin : g_hi
				assign cfg4_hi[4*(g-8)+:4] = {4{cfg_ok[g]}};
			end
		end
	endgenerate

	// ======================================================================
	// Next-state logic
	always_comb begin
		s_nxt = s_r;
		// Byte lanes turn into a bit mask so narrow writes touch only their lanes.
		wmask = {{8{s_r.w_strb[3]}}, {8{s_r.w_strb[2]}},
			{8{s_r.w_strb[1]}}, {8{s_r.w_strb[0]}}};
		wd = s_r.w_data & wmask;
		do_wr = s_r.aw_held && s_r.w_held && !s_r.axi.bvalid;
		do_rd = s_axi_arvalid && s_r.axi.arready;
		wr_hit = 1'b1;
		rd_hit = 1'b1;
		rd_val = 32'h0000_0000;
		lk_abort = 1'b0;

		// Address and data are captured independently, in either order.
		s_nxt.axi.awready = !s_r.aw_held && !s_nxt.aw_held;
		if (s_axi_awvalid && s_r.axi.awready) begin
			s_nxt.aw_held = 1'b1;
			s_nxt.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_r.axi.wready) begin
			s_nxt.w_held = 1'b1;
			s_nxt.w_data = s_axi_wdata;
			s_nxt.w_strb = s_axi_wstrb;
		end

		if (do_wr) begin
			case ({s_r.aw_addr[7:2], 2'h0})
				`GPM_OFS_MODE: s_nxt.mode = (s_r.mode & ~(wmask & cfg2_ok))
					| (wd & cfg2_ok);
				`GPM_OFS_OTYPE: s_nxt.otype = (s_r.otype & ~(wmask[15:0] & cfg_ok))
					| (wd[15:0] & cfg_ok);
				`GPM_OFS_DRIVE: s_nxt.drive = (s_r.drive & ~(wmask & cfg2_ok))
					| (wd & cfg2_ok);
				`GPM_OFS_PULL: s_nxt.pull = (s_r.pull & ~(wmask & cfg2_ok))
					| (wd & cfg2_ok);
				`GPM_OFS_INPUT: wr_hit = 1'b1;
				`GPM_OFS_LATCH: s_nxt.latch = (s_r.latch & ~wmask[15:0]) | wd[15:0];
				`GPM_OFS_SETCLR: s_nxt.latch = (s_r.latch & ~wd[31:`GPM_CLR_LSB])
					| wd[15:0];
				`GPM_OFS_LOCK: begin
					if (!s_r.locked) begin
						lk_abort = wmask[15:0] != 16'h0000 && s_r.lock_st != gpm_pkg::GPM_LK_IDLE
							&& (wd[15:0] | (s_r.lock_mask & ~wmask[15:0])) != s_r.lock_mask;
						if (lk_abort) begin
							// A changed mask aborts the sequence; this same write may open a new one.
							s_nxt.lock_st = gpm_pkg::GPM_LK_IDLE;
						end
						s_nxt.lock_mask = (s_r.lock_mask & ~wmask[15:0]) | wd[15:0];
						if (wmask[`GPM_LOCK_SEQ_BIT]) begin
							s_nxt.lock_seq = wd[`GPM_LOCK_SEQ_BIT];
							case (lk_abort ? gpm_pkg::GPM_LK_IDLE : s_r.lock_st)
								gpm_pkg::GPM_LK_IDLE: s_nxt.lock_st = wd[`GPM_LOCK_SEQ_BIT] ?
									gpm_pkg::GPM_LK_ONE : gpm_pkg::GPM_LK_IDLE;
								gpm_pkg::GPM_LK_ONE: s_nxt.lock_st = wd[`GPM_LOCK_SEQ_BIT] ?
									gpm_pkg::GPM_LK_ONE : gpm_pkg::GPM_LK_ZERO;
								gpm_pkg::GPM_LK_ZERO: s_nxt.lock_st = wd[`GPM_LOCK_SEQ_BIT] ?
									gpm_pkg::GPM_LK_TWO : gpm_pkg::GPM_LK_IDLE;
								default: s_nxt.lock_st = wd[`GPM_LOCK_SEQ_BIT] ?
									gpm_pkg::GPM_LK_ONE : gpm_pkg::GPM_LK_IDLE;
							endcase
						end
					end
				end
				`GPM_OFS_ALTLO: s_nxt.alt_lo = (s_r.alt_lo & ~(wmask & cfg4_lo))
					| (wd & cfg4_lo);
				`GPM_OFS_ALTHI: s_nxt.alt_hi = (s_r.alt_hi & ~(wmask & cfg4_hi))
					| (wd & cfg4_hi);
				`GPM_OFS_BITCLR: s_nxt.latch = s_r.latch & ~wd[15:0];
				`GPM_OFS_TOGGLE: s_nxt.latch = s_r.latch ^ wd[15:0];
				`GPM_OFS_HUGE: s_nxt.huge = (s_r.huge & ~(wmask[15:0] & cfg_ok))
					| (wd[15:0] & cfg_ok);
				default: wr_hit = 1'b0;
			endcase
			s_nxt.aw_held = 1'b0;
			s_nxt.w_held = 1'b0;
			s_nxt.axi.bvalid = 1'b1;
			s_nxt.axi.bresp = wr_hit ? `GPM_RESP_OKAY : `GPM_RESP_SLVERR;
		end else if (s_r.axi.bvalid && s_axi_bready) begin
			s_nxt.axi.bvalid = 1'b0;
		end
		s_nxt.axi.awready = !s_nxt.aw_held;
		s_nxt.axi.wready = !s_nxt.w_held;

		// Read path: one outstanding read, answered one cycle after acceptance.
		case ({s_araddr_word(s_axi_araddr), 2'h0})
			`GPM_OFS_MODE:   rd_val = s_r.mode;
			`GPM_OFS_OTYPE:  rd_val = {16'h0000, s_r.otype};
			`GPM_OFS_DRIVE:  rd_val = s_r.drive;
			`GPM_OFS_PULL:   rd_val = s_r.pull;
			`GPM_OFS_INPUT:  rd_val = {16'h0000, s_r.in_smp};
			`GPM_OFS_LATCH:  rd_val = {16'h0000, s_r.latch};
			`GPM_OFS_SETCLR: rd_val = 32'h0000_0000;
			`GPM_OFS_LOCK:   rd_val = {15'h0000, s_r.lock_seq, s_r.lock_mask};
			`GPM_OFS_ALTLO:  rd_val = s_r.alt_lo;
			`GPM_OFS_ALTHI:  rd_val = s_r.alt_hi;
			`GPM_OFS_BITCLR: rd_val = 32'h0000_0000;
			`GPM_OFS_TOGGLE: rd_val = 32'h0000_0000;
			`GPM_OFS_HUGE:   rd_val = {16'h0000, s_r.huge};
			default:         rd_hit = 1'b0;
		endcase
		if (do_rd) begin
			s_nxt.axi.rvalid = 1'b1;
			s_nxt.axi.rdata = rd_val;
			s_nxt.axi.rresp = rd_hit ? `GPM_RESP_OKAY : `GPM_RESP_SLVERR;
			// The read that closes the sequence is what arms the lock.
			if ({s_araddr_word(s_axi_araddr), 2'h0} == `GPM_OFS_LOCK
				&& s_r.lock_st == gpm_pkg::GPM_LK_TWO && !do_wr) begin
				s_nxt.lock_st = gpm_pkg::GPM_LK_DONE;
				s_nxt.locked = 1'b1;
			end
		end else if (s_r.axi.rvalid && s_axi_rready) begin
			s_nxt.axi.rvalid = 1'b0;
		end
		s_nxt.axi.arready = !s_nxt.axi.rvalid && !do_rd;

		s_nxt.in_smp = pin_in;

		// Pad drive: GPIO, alternate function, then hardware owners on top.
		for (int p = 0; p < 16; p++) begin
			s_nxt.alt_sel_valid[p] = (s_r.mode[2*p+:2] == gpm_pkg::GPM_MODE_ALT)
				|| (s_r.mode[2*p+:2] == gpm_pkg::GPM_MODE_INPUT);
			s_nxt.pad.analog[p] = (s_r.mode[2*p+:2] == gpm_pkg::GPM_MODE_ANALOG);
			case (s_r.mode[2*p+:2])
				gpm_pkg::GPM_MODE_OUTPUT: begin
					s_nxt.pad.out[p] = s_r.latch[p];
					// Open-drain releases the pin on a high bit.
					s_nxt.pad.oe_b[p] = s_r.otype[p] && s_r.latch[p];
				end
				gpm_pkg::GPM_MODE_ALT: begin
					s_nxt.pad.out[p] = alt_out[p];
					s_nxt.pad.oe_b[p] = alt_oe_b[p] || (s_r.otype[p] && alt_out[p]);
				end
				default: begin
					s_nxt.pad.out[p] = 1'b0;
					s_nxt.pad.oe_b[p] = 1'b1;
				end
			endcase
			s_nxt.pad.pull_up[p] = (s_r.pull[2*p+:2] == 2'h1);
			s_nxt.pad.pull_down[p] = (s_r.pull[2*p+:2] == 2'h2);
			s_nxt.pad.large_drive[p] = (s_r.drive[2*p+:2] == 2'h1);
			s_nxt.pad.huge_drive[p] = s_r.huge[p];
			if (owner.own[p]) begin
				// Owner wake, tamper, RTC or oscillator decode sits outside.
				s_nxt.pad.out[p] = owner.out[p];
				s_nxt.pad.oe_b[p] = owner.oe_b[p];
				s_nxt.pad.pull_up[p] = 1'b0;
				s_nxt.pad.pull_down[p] = 1'b0;
				s_nxt.pad.analog[p] = 1'b0;
				s_nxt.alt_sel_valid[p] = 1'b0;
			end
		end
	end

	function automatic logic [5:0] s_araddr_word(input logic [7:0] a);
		return a[7:2];
	endfunction : s_araddr_word

	// ======================================================================
	// State register
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			s_r <= '0;
			s_r.axi.awready <= 1'b1;
			s_r.axi.wready <= 1'b1;
			s_r.axi.arready <= 1'b1;
			s_r.mode <= MODE_RST;
			s_r.drive <= DRIVE_RST;
			s_r.pull <= PULL_RST;
			s_r.lock_st <= gpm_pkg::GPM_LK_IDLE;
			s_r.pad.oe_b <= 16'hFFFF;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign s_axi_awready   = s_r.axi.awready;
	assign s_axi_wready    = s_r.axi.wready;
	assign s_axi_bvalid    = s_r.axi.bvalid;
	assign s_axi_bresp     = s_r.axi.bresp;
	assign s_axi_arready   = s_r.axi.arready;
	assign s_axi_rvalid    = s_r.axi.rvalid;
	assign s_axi_rdata     = s_r.axi.rdata;
	assign s_axi_rresp     = s_r.axi.rresp;
	assign pin_out         = s_r.pad.out;
	assign pin_oe_b        = s_r.pad.oe_b;
	assign pin_pull_up     = s_r.pad.pull_up;
	assign pin_pull_down   = s_r.pad.pull_down;
	assign pin_large_drive = s_r.pad.large_drive;
	assign pin_huge_drive  = s_r.pad.huge_drive;
	assign pin_analog      = s_r.pad.analog;
	assign alt_in_valid    = s_r.alt_sel_valid;
	assign config_locked   = s_r.locked;
endmodule : gpm_port

// ==== gpm_port_assertions.sv ====
// Port-level checks for the pin-mux port.
`timescale 1ns/1ps
`include "gpm_consts.svh"
module gpm_port_chk (
	input  wire logic                clk,
	input  wire logic                rst_b,
	input  wire logic [7:0]          s_axi_araddr,
	input  wire logic                s_axi_arvalid,
	input  wire logic                s_axi_arready,
	input  wire logic [31:0]         s_axi_rdata,
	input  wire logic                s_axi_rvalid,
	input  wire logic                s_axi_rready,
	input  wire logic                s_axi_bvalid,
	input  wire logic [1:0]          s_axi_bresp,
	input  wire logic                s_axi_bready,
	input  wire gpm_pkg::gpm_owner_t owner,
	input  wire logic [15:0]         pin_out,
	input  wire logic [15:0]         pin_oe_b,
	input  wire logic [15:0]         pin_pull_up,
	input  wire logic [15:0]         pin_pull_down,
	input  wire logic                config_locked
);
	// ========================================
	// Helper registers
	logic [7:0] rd_addr_r;
	logic       lk_rd_r;
	always_ff @(posedge clk) begin
		if (s_axi_arvalid && s_axi_arready) begin
			rd_addr_r <= s_axi_araddr;
		end
		lk_rd_r <= s_axi_arvalid && s_axi_arready && (s_axi_araddr == `GPM_OFS_LOCK);
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	// ========================================
	// Assertions
	rst_state_a: assert property (disable iff (1'b0) !rst_b |=>
		(pin_oe_b == 16'hFFFF) && !s_axi_bvalid && !s_axi_rvalid) else $error("reset state wrong");
	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped early");
	b_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write answer repeated");
	r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped early");
	r_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answer pending");
	in_upper_a: assert property (s_axi_rvalid && (rd_addr_r == `GPM_OFS_INPUT) |->
		s_axi_rdata[31:16] == 16'h0000) else $error("input upper half not zero");
	pull_excl_a: assert property ((pin_pull_up & pin_pull_down) == 16'h0000)
		else $error("pull-up and pull-down together");
	owner_take_a: assert property ($stable(owner) ##1 $stable(owner) |->
		(((pin_out ^ owner.out) | (pin_oe_b ^ owner.oe_b)) & owner.own) == 16'h0000)
		else $error("owned pin not given to owner");
	lock_keep_a: assert property (config_locked |=> config_locked)
		else $error("lock released without reset");
	lock_read_a: assert property ($rose(config_locked) |-> lk_rd_r || $past(lk_rd_r))
		else $error("lock set without read");
	cover property (config_locked && s_axi_bvalid);
	cover property (s_axi_bvalid && !s_axi_bready);
	cover property (owner.own != 16'h0000);
endmodule : gpm_port_chk

// ==== gpm_pins.sv ====
// Pad-side model: resolves each pin level and feeds it back as input.
`timescale 1ns/1ps
module gpm_pins (
	input  wire logic [15:0] pin_out,
	input  wire logic [15:0] pin_oe_b,
	input  wire logic [15:0] pin_pull_up,
	input  wire logic [15:0] pin_pull_down,
	input  wire logic        clk,
	output logic [15:0]      pin_in
);
	// A pin nobody drives or pulls wanders each cycle, so a stale level never passes.
	logic [15:0] float_r = 16'h0000;
	always_ff @(posedge clk) begin
		float_r <= ~float_r;
	end
	always_comb begin
		for (int p = 0; p < 16; p++) begin
			if (!pin_oe_b[p]) begin
				pin_in[p] = pin_out[p];
			end else if (pin_pull_up[p]) begin
				pin_in[p] = 1'b1;
			end else if (pin_pull_down[p]) begin
				pin_in[p] = 1'b0;
			end else begin
				pin_in[p] = float_r[p];
			end
		end
	end
endmodule : gpm_pins

// ==== tb.sv ====
// Self-checking bench for the pin-mux port.
`timescale 1ns/1ps
`include "gpm_consts.svh"
module tb;
	logic                clk, rst_b, config_locked;
	logic [7:0]          s_axi_awaddr, s_axi_araddr;
	logic [31:0]         s_axi_wdata, s_axi_rdata, rd;
	logic [3:0]          s_axi_wstrb;
	logic                s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic                s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic                s_axi_rvalid, s_axi_rready;
	logic [1:0]          s_axi_bresp, s_axi_rresp, rsp;
	logic [15:0]         pin_in, pin_out, pin_oe_b, pin_pull_up, pin_pull_down, lat;
	logic [15:0]         pin_large_drive, pin_huge_drive, pin_analog, alt_in_valid;
	logic [255:0]        periph_out, periph_oe_b;
	gpm_pkg::gpm_owner_t owner;
	int                  fails = 0;
	int                  tests_run = 0;

	gpm_port u_dut (.clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .pin_in, .periph_out, .periph_oe_b, .owner, .pin_out,
		.pin_oe_b, .pin_pull_up, .pin_pull_down, .pin_large_drive, .pin_huge_drive,
		.pin_analog, .alt_in_valid, .config_locked);
	gpm_pins u_pins (.pin_out, .pin_oe_b, .pin_pull_up, .pin_pull_down, .clk, .pin_in);

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// ========================================
	// Bus and compare tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		@(negedge clk);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// Ready levels are read mid-cycle, where they equal what the next rising edge samples.
	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		logic ha, hw, hb;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(negedge clk);
			ha = s_axi_awvalid && s_axi_awready;
			hw = s_axi_wvalid && s_axi_wready;
			hb = s_axi_bvalid;
			rsp = s_axi_bresp;
			@(posedge clk);
			if (ha) s_axi_awvalid <= 1'b0;
			if (hw) s_axi_wvalid <= 1'b0;
		end while (!hb);
		s_axi_bready <= 1'b0;
		@(negedge clk);
	endtask : axw
	task automatic axr(input logic [7:0] a);
		logic ha, hb;
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(negedge clk);
			ha = s_axi_arvalid && s_axi_arready;
			hb = s_axi_rvalid;
			rd = s_axi_rdata;
			rsp = s_axi_rresp;
			@(posedge clk);
			if (ha) s_axi_arvalid <= 1'b0;
		end while (!hb);
		s_axi_rready <= 1'b0;
		@(negedge clk);
	endtask : axr
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		axr(a);
		chk(rd, e);
	endtask : rchk
	// ========================================
	// Scenarios
	task automatic t_reset;
		rchk(`GPM_OFS_MODE, `GPM_MODE_RST_A);
		rchk(`GPM_OFS_OTYPE, 32'h0000_0000);
		rchk(`GPM_OFS_DRIVE, 32'h0000_0000);
		rchk(`GPM_OFS_PULL, `GPM_PULL_RST_A);
		rchk(`GPM_OFS_LATCH, 32'h0000_0000);
		rchk(`GPM_OFS_ALTLO, 32'h0000_0000);
		rchk(`GPM_OFS_ALTHI, 32'h0000_0000);
		rchk(`GPM_OFS_HUGE, 32'h0000_0000);
		chk(pin_pull_up, 16'h2000);
		chk(pin_pull_down, 16'h4000);
		axr(8'h40);
		chk(rsp, `GPM_RESP_SLVERR);
		axw(8'h44, 32'hFFFF_FFFF, 4'hF);
		chk(rsp, `GPM_RESP_SLVERR);
	endtask : t_reset
	task automatic t_modes;
		logic [1:0] c;
		for (int i = 0; i < 4; i++) begin
			c = i[1:0];
			axw(`GPM_OFS_MODE, {16{c}}, 4'hF);
			chk(pin_analog, (c == 2'h3) ? 16'hFFFF : 16'h0000);
			chk(alt_in_valid, c[0] ? 16'h0000 : 16'hFFFF);
			chk(pin_oe_b, (c == 2'h1) ? 16'h0000 : 16'hFFFF);
		end
	endtask : t_modes
	task automatic t_latch;
		axw(`GPM_OFS_MODE, 32'h5555_5555, 4'hF);
		axw(`GPM_OFS_LATCH, 32'h0000_A5A5, 4'hF);
		axw(`GPM_OFS_SETCLR, 32'h00FF_0F0F, 4'hF);
		lat = (16'hA5A5 | 16'h0F0F) & ~(16'h00FF & ~16'h0F0F);
		rchk(`GPM_OFS_LATCH, {16'h0000, lat});
		// Only byte lane 0 is strobed, so the clear half must be ignored.
		axw(`GPM_OFS_SETCLR, 32'hFFFF_00F0, 4'h1);
		lat = lat | 16'h00F0;
		rchk(`GPM_OFS_LATCH, {16'h0000, lat});
		axw(`GPM_OFS_BITCLR, 32'hFFFF_000F, 4'hF);
		lat = lat & ~16'h000F;
		rchk(`GPM_OFS_LATCH, {16'h0000, lat});
		axw(`GPM_OFS_TOGGLE, 32'h0000_FFFF, 4'h3);
		lat = ~lat;
		rchk(`GPM_OFS_TOGGLE, 32'h0000_0000);
		rchk(`GPM_OFS_LATCH, {16'h0000, lat});
		chk(pin_out, lat);
		rchk(`GPM_OFS_INPUT, {16'h0000, lat});
	endtask : t_latch
	task automatic t_pads;
		axw(`GPM_OFS_DRIVE, 32'h0000_002D, 4'hF);
		axw(`GPM_OFS_HUGE, 32'h0000_8001, 4'hF);
		axw(`GPM_OFS_PULL, 32'h0000_0009, 4'hF);
		axw(`GPM_OFS_OTYPE, 32'h0000_0001, 4'hF);
		for (int v = 0; v < 2; v++) begin
			axw(`GPM_OFS_LATCH, v, 4'hF);
			chk(pin_oe_b, v[15:0]);
		end
		chk(pin_large_drive, 16'h0001);
		chk(pin_huge_drive, 16'h8001);
		chk(pin_pull_up, 16'h0001);
		chk(pin_pull_down, 16'h0002);
	endtask : t_pads
	task automatic t_mux;
		axw(`GPM_OFS_MODE, 32'hAAAA_AAAA, 4'hF);
		axw(`GPM_OFS_OTYPE, 32'h0000_0000, 4'hF);
		axw(`GPM_OFS_ALTLO, 32'h7654_3210, 4'hF);
		axw(`GPM_OFS_ALTHI, 32'hFEDC_BA98, 4'hF);
		rchk(`GPM_OFS_ALTHI, 32'hFEDC_BA98);
		for (int k = 0; k < 2; k++) begin
			@(posedge clk);
			for (int p = 0; p < 16; p++) begin
				periph_out[16*p +: 16] <= (k == 1) ? ~(16'h0001 << p) : (16'h0001 << p);
				periph_oe_b[16*p +: 16] <= (k == 1) ? (16'h0001 << p) : ~(16'h0001 << p);
			end
			repeat (2) @(negedge clk);
			chk(pin_out, (k == 1) ? 16'h0000 : 16'hFFFF);
			chk(pin_oe_b, (k == 1) ? 16'hFFFF : 16'h0000);
		end
	endtask : t_mux
	task automatic t_lock;
		// A mask change in mid-sequence restarts it, so this attempt must not lock.
		axw(`GPM_OFS_LOCK, 32'h0001_0001, 4'hF);
		axw(`GPM_OFS_LOCK, 32'h0000_0003, 4'hF);
		axw(`GPM_OFS_LOCK, 32'h0001_0003, 4'hF);
		axr(`GPM_OFS_LOCK);
		chk(config_locked, 32'h0000_0000);
		axw(`GPM_OFS_LOCK, 32'h0001_0001, 4'hF);
		axw(`GPM_OFS_LOCK, 32'h0000_0001, 4'hF);
		axw(`GPM_OFS_LOCK, 32'h0001_0001, 4'hF);
		chk(config_locked, 32'h0000_0000);
		axr(`GPM_OFS_LOCK);
		chk(config_locked, 32'h0000_0001);
		axw(`GPM_OFS_MODE, 32'h5555_5555, 4'hF);
		rchk(`GPM_OFS_MODE, 32'h5555_5556);
	endtask : t_lock
	task automatic t_owner;
		axw(`GPM_OFS_LATCH, 32'h0000_0000, 4'hF);
		@(posedge clk);
		owner <= '{own: 16'h8002, out: 16'h8000, oe_b: 16'h0002};
		repeat (2) @(negedge clk);
		chk(pin_out & 16'h8002, 16'h8000);
		chk(pin_oe_b & 16'h8002, 16'h0002);
		chk(alt_in_valid & 16'h8002, 16'h0000);
		@(posedge clk);
		owner <= '{own: 16'h0000, out: 16'h0000, oe_b: 16'hFFFF};
		repeat (2) @(negedge clk);
		chk(pin_oe_b & 16'h8002, 16'h0000);
	endtask : t_owner
	// ========================================
	// Verdict, main sequence and watchdog
	task automatic print_verdict;
		if (fails == 0 && tests_run > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : print_verdict
	initial begin
		rst_b = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
		periph_out = '0;
		periph_oe_b = '1;
		owner = '{own: 16'h0000, out: 16'h0000, oe_b: 16'hFFFF};
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		t_reset();
		t_modes();
		t_latch();
		t_pads();
		t_mux();
		t_lock();
		t_owner();
		print_verdict();
	end
	// The whole sequence needs under three hundred cycles; reaching 10,000 cycles means a hang.
	initial begin
		#1_000_000;
		fails++;
		print_verdict();
	end
endmodule : tb

bind gpm_port gpm_port_chk u_chk (.clk, .rst_b, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .s_axi_bvalid, .s_axi_bresp, .s_axi_bready,
	.owner, .pin_out, .pin_oe_b, .pin_pull_up, .pin_pull_down, .config_locked);
